/* common/bst_pkg.sv */
// Constants for the boundary-scan test port controller.
// Assumes a test clock from an outside tester and a core reference clock.
package bst_pkg;

	// ==========================================
	// Instruction register
	localparam int IR_W = 3;
	localparam logic [2:0] IR_EXTEST = 3'h0;
	localparam logic [2:0] IR_IDCODE = 3'h1;
	localparam logic [2:0] IR_SAMPLE = 3'h2;
	localparam logic [2:0] IR_CLAMP = 3'h3;
	localparam logic [2:0] IR_HIGHZ = 3'h4;
	localparam logic [2:0] IR_BYPASS = 3'h7;
	// Fixed capture pattern, shifted out low bit first
	localparam logic [2:0] IR_CAPTURE = 3'h1;

	// ==========================================
	// Data registers
	localparam int ID_W = 32;
	localparam int BSR_LEN = 8;
	localparam logic BYP_CAPTURE = 1'h0;

	// ==========================================
	// Controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} bst_state_e;

endpackage

/* core/bst_tap.sv */
// Boundary-scan test access port controller with its scan registers.
// Assumes the tester drives clock, mode select, serial in and reset;
// the core side gives pin samples on ref_clk_i and reads test modes.
//
// Behaviour
// - State moves only on rising test clock, by sampled mode select, or at once to reset on either reset.
// - Power-up leaves reset state, identity instruction, system normal.
// - Idle state holds instruction and data registers.
// - Select-DR: low to Capture-DR, high to Select-IR; registers hold.
// - Capture-DR loads selected register when instruction asks, else holds.
// - Capture-DR: low to Shift-DR, high to Exit1-DR.
// - Shift-DR shifts selected register toward serial out; others hold.
// - Exit1-DR: high to Update-DR, low to Pause-DR.
// - Pause-DR holds registers; stays while low, high to Exit2-DR.
// - Exit2-DR: high to Update-DR, low back to Shift-DR.
// - Update-DR falling edge copies boundary shift path into output latches, under extest and sample only.
// - Select-IR: low to Capture-IR, high to reset; instruction unchanged.
// - Capture-IR loads fixed value; high to Exit1-IR, low Shift-IR.
// - Shift-IR shifts instruction stage only; high goes Exit1-IR.
// - Exit1-IR: low to Pause-IR, high to Update-IR.
// - Pause-IR halts shifting; stays while low, high to Exit2-IR.
// - Update-IR falling edge latches new current instruction.
// - Update-IR: low to idle, high to Select-DR.
// - Supports sample, bypass, extest, highz, clamp and identity codes.
// - Five test pins; tester drives all but serial out.
// - Test clock may stop high or low; state is kept.
// - Instruction register three bits, shift stage plus parallel latch.
// - Captured instruction pattern shifts out 1 then 0.
// - One-bit bypass path under bypass, clamp and highz.
// - 32-bit identity register, selected by identity and reset; LSB one.
`timescale 1ns/100ps

module bst_tap #(
	parameter int BSR_W = bst_pkg::BSR_LEN,
	// Arbitrary identity value, bit 0 set
	parameter logic [31:0] ID_VALUE = 32'h1234_5001
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic test_port_clock_i,
	input wire logic test_port_reset_n_i,
	input wire logic test_port_mode_select_i,
	input wire logic test_port_serial_in_i,
	output logic test_port_serial_out_o,
	output logic test_port_serial_out_oe_n_o,
	input wire logic [BSR_W-1:0] bsr_pin_i,
	output logic [BSR_W-1:0] bsr_out_o,
	output logic extest_mode_o,
	output logic clamp_mode_o,
	output logic highz_mode_o
);

	// ==========================================
	// Test clock domain reset
	logic tck_arst_n;
	logic trst_s1_ff;
	logic trst_s2_ff;
	logic tck_rst_n;

	// Either reset source forces the controller at once
	assign tck_arst_n = test_port_reset_n_i & nrst_i;

	always_ff @(posedge test_port_clock_i or negedge tck_arst_n) begin
		if (!tck_arst_n) begin
			trst_s1_ff <= 1'h0;
			trst_s2_ff <= 1'h0;
		end else begin
			trst_s1_ff <= 1'h1;
			trst_s2_ff <= trst_s1_ff;
		end
	end

	// Release is clean, assertion still immediate
	assign tck_rst_n = trst_s2_ff & tck_arst_n;

	// ==========================================
	// State machine
	bst_pkg::bst_state_e state_ff;
	bst_pkg::bst_state_e nxt_state;
	logic tms;

	assign tms = test_port_mode_select_i;

	// Next state from mode select level
	always_comb begin
		case (state_ff)
			bst_pkg::ST_RESET: begin
				nxt_state = tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
			end
			bst_pkg::ST_IDLE: begin
				nxt_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			end
			bst_pkg::ST_SEL_DR: begin
				nxt_state = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			end
			bst_pkg::ST_CAP_DR: begin
				nxt_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			end
			bst_pkg::ST_SH_DR: begin
				nxt_state = tms ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			end
			bst_pkg::ST_EX1_DR: begin
				nxt_state = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
			end
			bst_pkg::ST_PAU_DR: begin
				nxt_state = tms ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
			end
			bst_pkg::ST_EX2_DR: begin
				nxt_state = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
			end
			bst_pkg::ST_UPD_DR: begin
				nxt_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			end
			bst_pkg::ST_SEL_IR: begin
				nxt_state = tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
			end
			bst_pkg::ST_CAP_IR: begin
				nxt_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			end
			bst_pkg::ST_SH_IR: begin
				nxt_state = tms ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			end
			bst_pkg::ST_EX1_IR: begin
				nxt_state = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
			end
			bst_pkg::ST_PAU_IR: begin
				nxt_state = tms ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
			end
			bst_pkg::ST_EX2_IR: begin
				nxt_state = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
			end
			bst_pkg::ST_UPD_IR: begin
				nxt_state = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
			end
			default: begin
				nxt_state = bst_pkg::ST_RESET;
			end
		endcase
	end

	always_ff @(posedge test_port_clock_i or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			state_ff <= bst_pkg::ST_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// State decodes
	logic in_reset;
	logic cap_dr;
	logic sh_dr;
	logic upd_dr;
	logic cap_ir;
	logic sh_ir;
	logic upd_ir;
	assign in_reset = (state_ff == bst_pkg::ST_RESET);
	assign cap_dr = (state_ff == bst_pkg::ST_CAP_DR);
	assign sh_dr = (state_ff == bst_pkg::ST_SH_DR);
	assign upd_dr = (state_ff == bst_pkg::ST_UPD_DR);
	assign cap_ir = (state_ff == bst_pkg::ST_CAP_IR);
	assign sh_ir = (state_ff == bst_pkg::ST_SH_IR);
	assign upd_ir = (state_ff == bst_pkg::ST_UPD_IR);

	// ==========================================
	// Instruction register
	logic [2:0] ir_sh_ff;
	logic [2:0] ir_cur_ff;
	logic [2:0] nxt_ir_sh;

	assign nxt_ir_sh = cap_ir ? bst_pkg::IR_CAPTURE :
		sh_ir ? {test_port_serial_in_i, ir_sh_ff[2:1]} : ir_sh_ff;

	always_ff @(posedge test_port_clock_i or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			ir_sh_ff <= bst_pkg::IR_CAPTURE;
		end else begin
			ir_sh_ff <= nxt_ir_sh;
		end
	end

	always_ff @(negedge test_port_clock_i or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			ir_cur_ff <= bst_pkg::IR_IDCODE;
		end else if (in_reset) begin
			ir_cur_ff <= bst_pkg::IR_IDCODE;
		end else if (upd_ir) begin
			ir_cur_ff <= ir_sh_ff;
		end
	end

	logic sel_bsr;
	logic sel_id;
	logic sel_byp;
	logic do_sample;
	assign sel_bsr = (ir_cur_ff == bst_pkg::IR_EXTEST) |
		(ir_cur_ff == bst_pkg::IR_SAMPLE);
	assign do_sample = sel_bsr;
	assign sel_id = (ir_cur_ff == bst_pkg::IR_IDCODE) | in_reset;
	assign sel_byp = ~sel_bsr & ~sel_id;

	// ==========================================
	// Data registers
	logic [BSR_W-1:0] pin_s1_ff;
	logic [BSR_W-1:0] pin_s2_ff;
	logic [BSR_W-1:0] pin_s3_ff;
	logic [BSR_W-1:0] pin_ok_ff;
	logic [BSR_W-1:0] bsr_sh_ff;
	logic [BSR_W-1:0] bsr_upd_ff;
	logic [31:0] id_sh_ff;
	logic byp_ff;
	logic tdi;
	assign tdi = test_port_serial_in_i;

	// Pin samples come from the core clock; a word is kept only when two
	// samples agree, so capture never sees a torn word (needs test clocks)
	always_ff @(posedge test_port_clock_i or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_s3_ff <= '0;
			pin_ok_ff <= '0;
		end else begin
			pin_s1_ff <= bsr_pin_i;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			if (pin_s2_ff == pin_s3_ff) begin
				pin_ok_ff <= pin_s3_ff;
			end
		end
	end

	// Next value of each data register
	logic [BSR_W-1:0] nxt_bsr_sh;
	logic [31:0] nxt_id_sh;
	logic nxt_byp;
	assign nxt_bsr_sh = (cap_dr & do_sample) ? pin_ok_ff :
		(sh_dr & sel_bsr) ? {tdi, bsr_sh_ff[BSR_W-1:1]} : bsr_sh_ff;
	assign nxt_id_sh = (cap_dr & sel_id) ? ID_VALUE :
		(sh_dr & sel_id) ? {tdi, id_sh_ff[31:1]} : id_sh_ff;
	assign nxt_byp = (cap_dr & sel_byp) ? bst_pkg::BYP_CAPTURE :
		(sh_dr & sel_byp) ? tdi : byp_ff;

	always_ff @(posedge test_port_clock_i or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			bsr_sh_ff <= '0;
			id_sh_ff <= ID_VALUE;
			byp_ff <= 1'h0;
		end else begin
			bsr_sh_ff <= nxt_bsr_sh;
			id_sh_ff <= nxt_id_sh;
			byp_ff <= nxt_byp;
		end
	end

	// ==========================================
	// Falling edge outputs
	logic upd_tgl_ff;
	logic tdo_ff;
	logic tdo_oe_n_ff;
	logic dr_out;
	assign dr_out = sel_bsr ? bsr_sh_ff[0] :
		sel_id ? id_sh_ff[0] : byp_ff;

	always_ff @(negedge test_port_clock_i or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			bsr_upd_ff <= '0;
			upd_tgl_ff <= 1'h0;
		end else if (upd_dr & sel_bsr) begin
			bsr_upd_ff <= bsr_sh_ff;
			upd_tgl_ff <= ~upd_tgl_ff;
		end
	end

	always_ff @(negedge test_port_clock_i or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			tdo_ff <= 1'h0;
			tdo_oe_n_ff <= 1'h1;
		end else begin
			tdo_ff <= sh_ir ? ir_sh_ff[0] : dr_out;
			tdo_oe_n_ff <= ~(sh_ir | sh_dr);
		end
	end

	assign test_port_serial_out_o = tdo_ff;
	assign test_port_serial_out_oe_n_o = tdo_oe_n_ff;

	// ==========================================
	// Core clock domain
	logic rst_s1_ff;
	logic rst_n_ff;

	// Reset release through two flops
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_ff <= 1'h0;
			rst_n_ff <= 1'h0;
		end else begin
			rst_s1_ff <= 1'h1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	// Mode levels and update toggle cross here
	logic [3:0] lvl_tck;
	logic [3:0] lvl_s1_ff;
	logic [3:0] lvl_s2_ff;
	logic [3:0] lvl_s3_ff;
	logic tgl_edge;
	logic mode_ok;
	assign lvl_tck = {upd_tgl_ff,
		ir_cur_ff == bst_pkg::IR_EXTEST,
		ir_cur_ff == bst_pkg::IR_CLAMP,
		ir_cur_ff == bst_pkg::IR_HIGHZ};
	assign tgl_edge = lvl_s2_ff[3] ^ lvl_s3_ff[3];
	// Mode bits form one word; accept it only when two samples match
	assign mode_ok = (lvl_s2_ff[2:0] == lvl_s3_ff[2:0]);

	// Two synchroniser stages, then one compare stage
	always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			lvl_s1_ff <= '0;
			lvl_s2_ff <= '0;
			lvl_s3_ff <= '0;
		end else begin
			lvl_s1_ff <= lvl_tck;
			lvl_s2_ff <= lvl_s1_ff;
			lvl_s3_ff <= lvl_s2_ff;
		end
	end

	// Latched word is stable long after the toggle
	always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			bsr_out_o <= '0;
			extest_mode_o <= 1'h0;
			clamp_mode_o <= 1'h0;
			highz_mode_o <= 1'h0;
		end else begin
			if (tgl_edge) begin
				bsr_out_o <= bsr_upd_ff;
			end
			if (mode_ok) begin
				extest_mode_o <= lvl_s3_ff[2];
				clamp_mode_o <= lvl_s3_ff[1];
				highz_mode_o <= lvl_s3_ff[0];
			end
		end
	end

endmodule

/* testbench/bst_tap_checker.sv */
// Port checker for the test port controller.
// Assumes the tester moves the test clock slowly against ref_clk_i.
`timescale 1ns/100ps

module bst_tap_checker #(
	parameter int BSR_W = 8
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic test_port_clock_i,
	input wire logic test_port_reset_n_i,
	input wire logic test_port_mode_select_i,
	input wire logic test_port_serial_in_i,
	input wire logic test_port_serial_out_o,
	input wire logic test_port_serial_out_oe_n_o,
	input wire logic [BSR_W-1:0] bsr_pin_i,
	input wire logic [BSR_W-1:0] bsr_out_o,
	input wire logic extest_mode_o,
	input wire logic clamp_mode_o,
	input wire logic highz_mode_o
);
	// ==========================================
	// Short names
	wire tck = test_port_clock_i;
	wire tm = test_port_mode_select_i;
	wire oe_n = test_port_serial_out_oe_n_o;
	wire so = test_port_serial_out_o;
	wire rst_t = !test_port_reset_n_i || !nrst_i;
	wire [2:0] modes = {extest_mode_o, clamp_mode_o, highz_mode_o};
	logic fall_tgl;

	// Flips on each falling test clock, the only edge that moves serial out
	always_ff @(negedge tck or posedge rst_t) begin
		if (rst_t) begin
			fall_tgl <= 1'h0;
		end else begin
			fall_tgl <= ~fall_tgl;
		end
	end

	// ==========================================
	// Test clock domain: walks from reset, shift exit and pause loop
	sequence s_rst_sel;
		tm [*5] ##1 !tm ##1 tm;
	endsequence
	AST_WALK_DR: assert property (@(posedge tck) disable iff (rst_t)
		s_rst_sel ##1 (!tm) [*2] |=> !oe_n && so)
		else $error("shift-DR walk wrong");
	AST_WALK_IR: assert property (@(posedge tck) disable iff (rst_t)
		s_rst_sel ##1 tm ##1 (!tm) [*2] |=> !oe_n && so)
		else $error("shift-IR walk wrong");
	AST_SH_EXIT: assert property (@(posedge tck) disable iff (rst_t)
		!oe_n && tm |=> oe_n)
		else $error("shift exit wrong");
	AST_EX2_LOOP: assert property (@(posedge tck) disable iff (rst_t)
		!oe_n && tm ##1 (!tm) [*2] ##1 tm ##1 !tm |=> !oe_n)
		else $error("pause loop wrong");

	// ==========================================
	// Core clock domain: reset, hold and one-hot modes
	AST_RST_OUT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		!test_port_reset_n_i |-> oe_n && !so)
		else $error("reset output wrong");
	AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_t)
		$stable(fall_tgl) |-> $stable(so) && $stable(oe_n))
		else $error("output moved without clock");
	AST_MODE_ONE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		$onehot0(modes))
		else $error("two modes at once");
	AST_RST_MODE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(!test_port_reset_n_i) [*5] |-> modes == 3'h0)
		else $error("mode left on in reset");

	// Main scenarios
	cover property (@(posedge tck) !oe_n && tm ##1 (!tm) [*2] ##1 tm ##1 !tm);
	cover property (@(posedge ref_clk_i) $rose(extest_mode_o));
	cover property (@(posedge ref_clk_i) $fell(test_port_reset_n_i));
endmodule

/* testbench/bst_tester.sv */
// Tester model: drives test clock, mode select, serial in and reset.
// Assumes the bench calls step once per bit; the clock rests high between steps.
`timescale 1ns/100ps

module bst_tester (
	output logic test_port_clock_o,
	output logic test_port_reset_n_o,
	output logic test_port_mode_select_o,
	output logic test_port_serial_in_o,
	input wire logic test_port_serial_out_i
);
	// Idle levels, reset held
	initial begin
		test_port_clock_o = 1'h0;
		test_port_reset_n_o = 1'h0;
		test_port_mode_select_o = 1'h1;
		test_port_serial_in_o = 1'h0;
	end

	// Clock stops high
	// Pins change 2 ns after a rising edge; period 48 ns, 24 high, 24 low
	task automatic step(input logic ms, input logic din, output logic dout);
		test_port_mode_select_o = ms;
		test_port_serial_in_o = din;
		#22;
		test_port_clock_o = 1'h0;
		#24;
		dout = test_port_serial_out_i;
		test_port_clock_o = 1'h1;
		#2;
	endtask

	task automatic set_reset(input logic v);
		test_port_reset_n_o = v;
	endtask
endmodule

/* testbench/tb.sv */
// Bench for the test port controller: scans, instructions, resets.
// Assumes the tester model steps the test clock; checker bound below.
`timescale 1ns/100ps

module tb;
	// Arbitrary identity value, bit 0 set
	localparam logic [31:0] IDV = 32'h1357_9BDF;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic tck;
	logic trst_n;
	logic tms;
	logic tdi;
	logic tdo;
	logic oe_n;
	logic [2:0] modes;
	logic [7:0] pins = 8'hA5;
	logic [7:0] bout;
	logic [31:0] got;
	int err_count = 0;
	int n_checks = 0;

	// ==========================================
	// Clock, tester and design
	always #20 ref_clk_i = ~ref_clk_i;

	bst_tester u_tst (
		.test_port_clock_o(tck),
		.test_port_reset_n_o(trst_n),
		.test_port_mode_select_o(tms),
		.test_port_serial_in_o(tdi),
		.test_port_serial_out_i(tdo)
	);

	bst_tap #(.BSR_W(8), .ID_VALUE(IDV)) u_dut (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.test_port_clock_i(tck),
		.test_port_reset_n_i(trst_n),
		.test_port_mode_select_i(tms),
		.test_port_serial_in_i(tdi),
		.test_port_serial_out_o(tdo),
		.test_port_serial_out_oe_n_o(oe_n),
		.bsr_pin_i(pins),
		.bsr_out_o(bout),
		.extest_mode_o(modes[2]),
		.clamp_mode_o(modes[1]),
		.highz_mode_o(modes[0])
	);

	// ==========================================
	// Shared tasks
	task automatic chk(input logic [31:0] a, input logic [31:0] e, input string m);
		n_checks++;
		if (a !== e) begin
			err_count++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask

	task automatic wait_ref();
		repeat (6) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic tap_reset();
		logic b;
		repeat (6) u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
	endtask

	// Idle to shift, n bits, optional pause after bit 1, update, idle
	task automatic scan(input bit ir, input bit pz, input int n, input logic [31:0] din);
		logic b;
		got = '0;
		u_tst.step(1'b1, 1'b0, b);
		if (ir) u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		for (int i = 0; i < n; i++) begin
			u_tst.step(i == n - 1 || (pz && i == 1), din[i], got[i]);
			if (pz && i == 1) begin
				u_tst.step(1'b0, 1'b0, b);
				u_tst.step(1'b0, 1'b0, b);
				u_tst.step(1'b1, 1'b0, b);
				u_tst.step(1'b0, 1'b0, b);
			end
		end
		u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
	endtask

	task automatic load_ir(input logic [2:0] code);
		scan(1'b1, 1'b0, 3, {29'h0, code});
		wait_ref();
	endtask

	// ==========================================
	// Scenarios
	task automatic t_scan();
		tap_reset();
		scan(1'b0, 1'b1, 32, 32'h0);
		chk(got, IDV, "identity shift");
		scan(1'b1, 1'b1, 3, 32'h7);
		chk(got[1:0], 2'h1, "ir capture");
		scan(1'b0, 1'b0, 8, 32'hC3);
		chk(got[7:0], 8'h86, "bypass path");
		$display("t_scan done");
	endtask

	task automatic t_boundary();
		load_ir(bst_pkg::IR_EXTEST);
		chk(modes, 3'h4, "extest mode");
		scan(1'b0, 1'b0, 8, 32'h3C);
		chk(got[7:0], 8'hA5, "extest capture");
		wait_ref();
		chk(bout, 8'h3C, "extest update");
		pins = 8'h0F;
		load_ir(bst_pkg::IR_SAMPLE);
		chk(modes, 3'h0, "sample mode");
		scan(1'b0, 1'b0, 8, 32'h5A);
		chk(got[7:0], 8'h0F, "sample capture");
		wait_ref();
		chk(bout, 8'h5A, "sample update");
		load_ir(bst_pkg::IR_CLAMP);
		chk(modes, 3'h2, "clamp mode");
		load_ir(bst_pkg::IR_HIGHZ);
		chk(modes, 3'h1, "highz mode");
		chk(bout, 8'h5A, "latch kept");
		tap_reset();
		scan(1'b0, 1'b0, 32, 32'h0);
		chk(got, IDV, "identity after tap reset");
		$display("t_boundary done");
	endtask

	task automatic t_reset_mid();
		logic b;
		load_ir(bst_pkg::IR_EXTEST);
		u_tst.step(1'b1, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		u_tst.step(1'b0, 1'b0, b);
		u_tst.step(1'b0, 1'b1, b);
		chk(oe_n, 1'b0, "shift drive");
		@(posedge ref_clk_i);
		#1;
		u_tst.set_reset(1'b0);
		wait_ref();
		chk({oe_n, modes}, 4'h8, "reset in shift");
		u_tst.set_reset(1'b1);
		tap_reset();
		scan(1'b1, 1'b0, 3, {29'h0, bst_pkg::IR_IDCODE});
		chk(got[1:0], 2'h1, "ir capture after reset");
		scan(1'b0, 1'b0, 32, 32'h0);
		chk(got, IDV, "identity after reset");
		$display("t_reset_mid done");
	endtask

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge ref_clk_i);
		#1;
		nrst_i = 1'b1;
		u_tst.set_reset(1'b1);
		wait_ref();
		t_scan();
		t_boundary();
		t_reset_mid();
		final_report();
	end

	// Watchdog
	initial begin
		#100000;
		err_count++;
		final_report();
	end
endmodule

bind bst_tap bst_tap_checker #(.BSR_W(BSR_W)) u_chk (
	.ref_clk_i(ref_clk_i),
	.nrst_i(nrst_i),
	.test_port_clock_i(test_port_clock_i),
	.test_port_reset_n_i(test_port_reset_n_i),
	.test_port_mode_select_i(test_port_mode_select_i),
	.test_port_serial_in_i(test_port_serial_in_i),
	.test_port_serial_out_o(test_port_serial_out_o),
	.test_port_serial_out_oe_n_o(test_port_serial_out_oe_n_o),
	.bsr_pin_i(bsr_pin_i),
	.bsr_out_o(bsr_out_o),
	.extest_mode_o(extest_mode_o),
	.clamp_mode_o(clamp_mode_o),
	.highz_mode_o(highz_mode_o)
);
